// >>> hw/cmpd_top.sv
// control-message parser and per-packet payload descrambler
`timescale 1ns/10ps
module cmpd_top
  import cmpd_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic [12:0]  ecm_pid_i,
  input  wire logic [255:0] sys_key_i,
  input  wire logic         in_valid_i,
  input  wire logic         in_sop_i,
  input  wire logic [7:0]   in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic              out_sop_o,
  output logic [7:0]        out_data_o,
  input  wire logic         out_ready_i,
  output logic              ecm_valid_o,
  output logic              crc_err_o,
  output logic [7:0]        protocol_o,
  output logic [7:0]        group_id_o,
  output logic [7:0]        work_key_id_o,
  output logic [63:0]       odd_key_o,
  output logic [63:0]       even_key_o,
  output logic [7:0]        prog_type_o,
  output logic [39:0]       date_time_o,
  output logic [7:0]        rec_ctrl_o,
  output logic [31:0]       mac_o
);
  // crc-32 over one byte, msb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ b[i]) ? CRC_POLY : 32'h0);
    end
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************
  cmpd_state_t st_q, st_d;
  cmpd_sec_t   sp_q, sp_d;
  logic [7:0]  idx_q, idx_d, pay_q, pay_d, skip_q, skip_d;
  logic [12:0] pid_q, pid_d, si_q, si_d, slen_q, slen_d;
  logic        pusi_q, pusi_d, afc_q, afc_d, scr_q, scr_d;
  logic        first_q, first_d, emit_q, emit_d;
  logic [63:0] pkey_q, pkey_d, blk_q, blk_d, ob_q, ob_d;
  logic [63:0] chain_q, chain_d, odd_sh_q, odd_sh_d;
  logic [63:0] even_sh_q, even_sh_d, odd_d, even_d;
  logic [3:0]  bcnt_q, bcnt_d, en_q, en_d;
  logic [31:0] crc_q, crc_d, mac_d;
  logic        ecmv_d, crce_d;
  logic [7:0]  prot_d, grp_d, wk_d, pt_d, rc_d;
  logic [39:0] dt_d;
  logic        acc, pay, to_blk, last, is_ecm;
  logic        f_vld, f_rdy;
  logic [8:0]  f_dat;
  logic [63:0] blk_full, c_in, c_out;

  // ****************************************
  // byte routing
  // ****************************************
  assign last     = (idx_q == PKT_LAST);
  assign pay      = afc_q && (idx_q >= pay_q) && (idx_q > IDX_CTRL);
  assign to_blk   = scr_q && pay;
  assign is_ecm   = (pid_q == ecm_pid_i);
  assign blk_full = {blk_q[55:0], in_data_i};
  // stall while a block drains, or when the fifo is full for direct bytes
  assign in_ready_o = !emit_q && (to_blk || f_rdy);
  assign acc = in_valid_i && in_ready_o;
  assign f_vld = emit_q || (acc && !to_blk && !(st_q == ST_WAIT &&
                 !in_sop_i));
  assign f_dat = emit_q ? {1'b0, ob_q[63:56]} :
                 {(st_q == ST_WAIT) || in_sop_i, in_data_i};
  // full block substituted, short tail xored with chained keystream
  assign c_in = (bcnt_q == BLK_BYTES - 4'd1) ? blk_full : chain_q;

  cmpd_cipher #(.ROUNDS(8)) u_ciph (
    .blk_i (c_in),
    .key_i (pkey_q),
    .sys_i (sys_key_i),
    .blk_o (c_out)
  );

  cmpd_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (f_vld),
    .in_data_i   (f_dat),
    .in_ready_o  (f_rdy),
    .out_valid_o (out_valid_o),
    .out_data_o  ({out_sop_o, out_data_o}),
    .out_ready_i (out_ready_i)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    st_d = st_q; sp_d = sp_q; idx_d = idx_q; pay_d = pay_q;
    skip_d = skip_q; pid_d = pid_q; si_d = si_q; slen_d = slen_q;
    pusi_d = pusi_q; afc_d = afc_q; scr_d = scr_q; first_d = first_q;
    emit_d = emit_q; pkey_d = pkey_q; blk_d = blk_q; ob_d = ob_q;
    chain_d = chain_q; bcnt_d = bcnt_q; en_d = en_q; crc_d = crc_q;
    odd_sh_d = odd_sh_q; even_sh_d = even_sh_q; odd_d = odd_key_o;
    even_d = even_key_o; mac_d = mac_o; ecmv_d = 1'b0;
    crce_d = crc_err_o; prot_d = protocol_o; grp_d = group_id_o;
    wk_d = work_key_id_o; pt_d = prog_type_o; dt_d = date_time_o;
    rc_d = rec_ctrl_o;
    // drain the output block one byte per fifo slot
    if (emit_q && f_rdy) begin
      ob_d = {ob_q[55:0], 8'h00};
      en_d = en_q - 4'd1;
      emit_d = (en_q != 4'd1);
    end
    if (acc) begin
      case (st_q)
        ST_WAIT: begin
          if (in_sop_i) begin
            st_d = ST_PKT;
            idx_d = 8'd1;
          end
        end
        default: begin
          idx_d = last ? 8'd0 : idx_q + 8'd1;
          if (last) begin
            st_d = ST_WAIT;
          end
          if (idx_q == IDX_PID_HI) begin
            pusi_d = in_data_i[PUSI_BIT];
            pid_d[12:8] = in_data_i[4:0];
          end
          if (idx_q == IDX_PID_LO) begin
            pid_d[7:0] = in_data_i;
          end
          if (idx_q == IDX_CTRL) begin
            afc_d = in_data_i[4];
            pay_d = in_data_i[5] ? PAY_AF_BASE : PAY_NO_AF;
            // tables and control messages are never descrambled
            scr_d = in_data_i[7] && (pid_q >= TABLE_PID_LIMIT) &&
                    !is_ecm;
            pkey_d = (in_data_i[7:6] == TSC_ODD) ? odd_key_o
                                                 : even_key_o;
            bcnt_d = 4'd0;
            chain_d = 64'h0;
            first_d = 1'b1;
          end
          if (idx_q == IDX_AF_LEN && pay_q == PAY_AF_BASE) begin
            pay_d = PAY_AF_BASE + in_data_i;
          end
          // gather scrambled payload into 64-bit blocks
          if (to_blk) begin
            blk_d = blk_full;
            bcnt_d = bcnt_q + 4'd1;
            if (bcnt_q == BLK_BYTES - 4'd1) begin
              ob_d = c_out;
              chain_d = last ? 64'h0 : blk_full;
              en_d = BLK_BYTES;
              emit_d = 1'b1;
              bcnt_d = 4'd0;
            end else if (last) begin
              // xor with keystream, then left-align the tail
              ob_d = (blk_full ^ c_out) <<
                     (6'(BLK_BYTES - 4'd1 - bcnt_q) * 6'd8);
              en_d = bcnt_q + 4'd1;
              emit_d = 1'b1;
              bcnt_d = 4'd0;
              chain_d = 64'h0;
            end
          end
          // section extraction on the control-message pid
          if (is_ecm && pay) begin
            first_d = 1'b0;
            if (first_q && pusi_q) begin
              skip_d = in_data_i;
              sp_d = (in_data_i == 8'd0) ? SP_SEC : SP_PTR;
              si_d = 13'd0;
              crc_d = CRC_INIT;
            end else begin
              case (sp_q)
                SP_PTR: begin
                  skip_d = skip_q - 8'd1;
                  if (skip_q == 8'd1) begin
                    sp_d = SP_SEC;
                  end
                end
                SP_SEC: begin
                  crc_d = crc_byte(crc_q, in_data_i);
                  si_d = si_q + 13'd1;
                  if (si_q == SEC_LEN_HI) begin
                    slen_d[11:8] = in_data_i[3:0];
                  end
                  if (si_q == SEC_LEN_LO) begin
                    slen_d[7:0] = in_data_i;
                  end
                  if (si_q == OFS_PROTO) prot_d = in_data_i;
                  if (si_q == OFS_GROUP) grp_d = in_data_i;
                  if (si_q == OFS_WKEY) wk_d = in_data_i;
                  if (si_q >= OFS_ODD && si_q < OFS_EVEN) begin
                    odd_sh_d = {odd_sh_q[55:0], in_data_i};
                  end
                  if (si_q >= OFS_EVEN && si_q < OFS_PTYPE) begin
                    even_sh_d = {even_sh_q[55:0], in_data_i};
                  end
                  if (si_q == OFS_PTYPE) pt_d = in_data_i;
                  if (si_q >= OFS_DTIME && si_q < OFS_REC) begin
                    dt_d = {date_time_o[31:0], in_data_i};
                  end
                  if (si_q == OFS_REC) rc_d = in_data_i;
                  // tamper code sits just ahead of the crc
                  if (si_q >= FIXED_END &&
                      si_q >= slen_q - MAC_FROM_END &&
                      si_q <= slen_q - MAC_TO_END) begin
                    mac_d = {mac_o[23:0], in_data_i};
                  end
                  if (si_q > SEC_LEN_LO &&
                      si_q == slen_q + SEC_LAST_ADJ) begin
                    sp_d = SP_IDLE;
                    ecmv_d = 1'b1;
                    crce_d = (crc_byte(crc_q, in_data_i) != 32'h0);
                    if (crc_byte(crc_q, in_data_i) == 32'h0) begin
                      odd_d = odd_sh_q;
                      even_d = even_sh_q;
                    end
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q <= ST_WAIT; sp_q <= SP_IDLE; idx_q <= '0; pay_q <= '0;
      skip_q <= '0; pid_q <= '0; si_q <= '0; slen_q <= '0;
      pusi_q <= 1'b0; afc_q <= 1'b0; scr_q <= 1'b0; first_q <= 1'b0;
      emit_q <= 1'b0; pkey_q <= '0; blk_q <= '0; ob_q <= '0;
      chain_q <= '0; bcnt_q <= '0; en_q <= '0; crc_q <= CRC_INIT;
      odd_sh_q <= '0; even_sh_q <= '0; odd_key_o <= '0;
      even_key_o <= '0; mac_o <= '0; ecm_valid_o <= 1'b0;
      crc_err_o <= 1'b0; protocol_o <= '0; group_id_o <= '0;
      work_key_id_o <= '0; prog_type_o <= '0; date_time_o <= '0;
      rec_ctrl_o <= '0;
    end else begin
      st_q <= st_d; sp_q <= sp_d; idx_q <= idx_d; pay_q <= pay_d;
      skip_q <= skip_d; pid_q <= pid_d; si_q <= si_d; slen_q <= slen_d;
      pusi_q <= pusi_d; afc_q <= afc_d; scr_q <= scr_d;
      first_q <= first_d; emit_q <= emit_d; pkey_q <= pkey_d;
      blk_q <= blk_d; ob_q <= ob_d; chain_q <= chain_d;
      bcnt_q <= bcnt_d; en_q <= en_d; crc_q <= crc_d;
      odd_sh_q <= odd_sh_d; even_sh_q <= even_sh_d; odd_key_o <= odd_d;
      even_key_o <= even_d; mac_o <= mac_d; ecm_valid_o <= ecmv_d;
      crc_err_o <= crce_d; protocol_o <= prot_d; group_id_o <= grp_d;
      work_key_id_o <= wk_d; prog_type_o <= pt_d; date_time_o <= dt_d;
      rec_ctrl_o <= rc_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_full_blk;
    acc && to_blk && bcnt_q == 4'd7;
  endsequence
  sequence s_tail;
    acc && to_blk && last && bcnt_q < 4'd7;
  endsequence

  property p_full_emit;
    s_full_blk |=> emit_q && en_q == 4'd8 ##1 !in_ready_o [*7];
  endproperty
  a_full_emit: assert property (p_full_emit)
    else $error("full block did not drain eight bytes");
  property p_tail;
    s_tail |=> emit_q && en_q == $past(bcnt_q) + 4'd1;
  endproperty
  a_tail: assert property (p_tail)
    else $error("tail length wrong");
  property p_pkt_reset;
    acc && st_q == ST_PKT && last |=> bcnt_q == 4'd0 && chain_q == '0;
  endproperty
  a_pkt_reset: assert property (p_pkt_reset)
    else $error("block state crossed packet boundary");
  property p_pass;
    acc && st_q == ST_PKT && !to_blk |-> f_vld && f_dat[7:0] == in_data_i;
  endproperty
  a_pass: assert property (p_pass)
    else $error("clear byte not passed unchanged");
  property p_key_sel;
    acc && st_q == ST_PKT && idx_q == IDX_CTRL |=>
      pkey_q == (($past(in_data_i[7:6]) == TSC_ODD) ?
                 $past(odd_key_o) : $past(even_key_o));
  endproperty
  a_key_sel: assert property (p_key_sel)
    else $error("packet key not chosen from scrambling bits");
  property p_key_swap;
    ecm_valid_o && !crc_err_o |-> odd_key_o == $past(odd_sh_q) &&
      even_key_o == $past(even_sh_q);
  endproperty
  a_key_swap: assert property (p_key_swap)
    else $error("good section did not load key pair");
  property p_bad_crc;
    ecm_valid_o && crc_err_o |-> $stable(odd_key_o) && $stable(even_key_o);
  endproperty
  a_bad_crc: assert property (p_bad_crc)
    else $error("keys changed on crc failure");
  property p_ptr;
    acc && is_ecm && pay && sp_q == SP_PTR && skip_q == 8'd1 &&
      !(first_q && pusi_q) |=> sp_q == SP_SEC && si_q == 13'd0;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("section did not start after pointer");
endmodule

// >>> hw/cmpd_pkg.sv
// shared constants and types of the control-message parser/descrambler
package cmpd_pkg;
  // ****************************************
  // transport packet layout
  // ****************************************
  localparam int unsigned PKT_LEN         = 188;
  localparam logic [7:0]  PKT_LAST        = 8'd187;
  localparam logic [7:0]  IDX_PID_HI      = 8'd1;
  localparam logic [7:0]  IDX_PID_LO      = 8'd2;
  localparam logic [7:0]  IDX_CTRL        = 8'd3;
  localparam logic [7:0]  IDX_AF_LEN      = 8'd4;
  localparam logic [7:0]  PAY_NO_AF       = 8'd4;
  localparam logic [7:0]  PAY_AF_BASE     = 8'd5;
  localparam int unsigned PUSI_BIT        = 6;
  localparam logic [12:0] TABLE_PID_LIMIT = 13'h0020;
  localparam logic [1:0]  TSC_ODD         = 2'h3;
  // ****************************************
  // control-message section layout
  // ****************************************
  localparam logic [12:0] SEC_LEN_HI  = 13'd1;
  localparam logic [12:0] SEC_LEN_LO  = 13'd2;
  localparam logic [12:0] OFS_PROTO   = 13'd8;
  localparam logic [12:0] OFS_GROUP   = 13'd9;
  localparam logic [12:0] OFS_WKEY    = 13'd10;
  localparam logic [12:0] OFS_ODD     = 13'd11;
  localparam logic [12:0] OFS_EVEN    = 13'd19;
  localparam logic [12:0] OFS_PTYPE   = 13'd27;
  localparam logic [12:0] OFS_DTIME   = 13'd28;
  localparam logic [12:0] OFS_REC     = 13'd33;
  localparam logic [12:0] FIXED_END   = 13'd34;
  localparam logic [12:0] MAC_FROM_END = 13'd5;
  localparam logic [12:0] MAC_TO_END  = 13'd2;
  localparam logic [12:0] SEC_LAST_ADJ = 13'd2;
  localparam logic [31:0] CRC_POLY    = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  // ****************************************
  // cipher, fifo depth and state encodings
  // ****************************************
  localparam logic [3:0]  BLK_BYTES = 4'd8;
  localparam int unsigned ROT_A     = 1;
  localparam int unsigned ROT_B     = 4;
  localparam int unsigned FIFO_DEPTH = 4;
  typedef enum logic {ST_WAIT, ST_PKT} cmpd_state_t;
  typedef enum logic [1:0] {SP_IDLE, SP_PTR, SP_SEC} cmpd_sec_t;
endpackage

// >>> hw/cmpd_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module cmpd_fifo
  import cmpd_pkg::*;
#(
  parameter int unsigned W = 9,
  parameter int unsigned D = 4
) (
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // honest full and empty from the count
  assign in_ready_o  = (cnt_q != (AW + 1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  // ****************************************
  // pointers
  // ****************************************
  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    if (push) begin
      wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
    end
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
endmodule

// >>> hw/cmpd_cipher.sv
// block transform: halves, rotations and or-mixing, key and system variable
`timescale 1ns/10ps
module cmpd_cipher
  import cmpd_pkg::*;
#(
  parameter int unsigned ROUNDS = 8
) (
  input  wire logic [63:0]  blk_i,
  input  wire logic [63:0]  key_i,
  input  wire logic [255:0] sys_i,
  output logic [63:0]       blk_o
);
  // circular left rotation of a 32-bit word
  function automatic logic [31:0] rotl(input logic [31:0] x,
                                       input int unsigned s);
    return (x << s) | (x >> (32 - s));
  endfunction

  logic [31:0] l_w [ROUNDS+1];
  logic [31:0] r_w [ROUNDS+1];

  // split into left and right halves
  assign l_w[0] = blk_i[63:32];
  assign r_w[0] = blk_i[31:0];

  // ****************************************
  // rounds: feistel form keeps every step reversible
  // ****************************************
  for (genvar g = 0; g < ROUNDS; g++) begin : g_rnd
    logic [31:0] sub_k, f_v;
    assign sub_k = sys_i[32*(g%8) +: 32] ^
                   ((g % 2 == 1) ? key_i[63:32] : key_i[31:0]);
    assign f_v = rotl(r_w[g] + sub_k, ROT_A) ^
                 (rotl(r_w[g], ROT_B) | sub_k);
    assign l_w[g+1] = r_w[g];
    assign r_w[g+1] = l_w[g] ^ f_v;
  end

  // halves rejoined by concatenation
  assign blk_o = {l_w[ROUNDS], r_w[ROUNDS]};
endmodule

// >>> verif/cmpd_sink_model.sv
// downstream sink model driving back-pressure on the output stream
`timescale 1ns/10ps
module cmpd_sink_model (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic hold_i,
  output logic      ready_o
);
  // ****************************************
  // back-pressure
  // ****************************************
  // random stalls reach fifo full and empty corners, hold_i stops all
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !hold_i && (($urandom % 4) != 0);
    end
  end
endmodule

// >>> verif/cmpd_top_bench.sv
// self-checking bench of the control-message parser and descrambler
`timescale 1ns/10ps
module cmpd_top_bench;
  import cmpd_pkg::*;
  logic         sys_clk_i  = 1'b0;
  logic         srst_i     = 1'b1;
  logic [12:0]  ecm_pid_i  = 13'h0000;
  logic [255:0] sys_key_i  = '0;
  logic         in_valid_i = 1'b0;
  logic         in_sop_i   = 1'b0;
  logic [7:0]   in_data_i  = 8'h00;
  logic         hold       = 1'b0;
  logic         in_ready_o, out_valid_o, out_sop_o, out_ready_i;
  logic         ecm_valid_o, crc_err_o;
  logic [7:0]   out_data_o, protocol_o, group_id_o, work_key_id_o;
  logic [7:0]   prog_type_o, rec_ctrl_o;
  logic [63:0]  odd_key_o, even_key_o, ko, ke;
  logic [39:0]  date_time_o;
  logic [31:0]  mac_o, seed_v;
  logic [7:0]   pkt [188];
  logic [7:0]   sec [$];
  logic [7:0]   got [$];
  logic         got_sop [$];
  int           mismatches = 0;
  int           n_compared = 0;
  int           n_ev       = 0;
  int           d1, d2, d3, d4, ns;

  cmpd_top cmpd_top_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .ecm_pid_i(ecm_pid_i), .sys_key_i(sys_key_i), .in_valid_i(in_valid_i),
    .in_sop_i(in_sop_i), .in_data_i(in_data_i), .in_ready_o(in_ready_o),
    .out_valid_o(out_valid_o), .out_sop_o(out_sop_o),
    .out_data_o(out_data_o), .out_ready_i(out_ready_i),
    .ecm_valid_o(ecm_valid_o), .crc_err_o(crc_err_o),
    .protocol_o(protocol_o), .group_id_o(group_id_o),
    .work_key_id_o(work_key_id_o), .odd_key_o(odd_key_o),
    .even_key_o(even_key_o), .prog_type_o(prog_type_o),
    .date_time_o(date_time_o), .rec_ctrl_o(rec_ctrl_o), .mac_o(mac_o));
  cmpd_sink_model cmpd_sink_model_inst (.sys_clk_i(sys_clk_i),
    .srst_i(srst_i), .hold_i(hold), .ready_o(out_ready_i));

  // 125 MHz clock
  always #4 sys_clk_i = ~sys_clk_i;

  // ****************************************
  // capture and helpers
  // ****************************************
  // output bytes and section pulses are logged at the sampling edge
  always @(posedge sys_clk_i) begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      got.push_back(out_data_o);
      got_sop.push_back(out_sop_o);
    end
    if (ecm_valid_o === 1'b1) n_ev++;
  end

  task automatic chk(input logic [63:0] act, input logic [63:0] exp);
    n_compared++;
    if (act !== exp) begin
      mismatches++;
      $display("[ERR] %0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // crc over msb-first bits, the receiver checks a zero residue
  function automatic logic [31:0] crc_of(input logic [7:0] b [$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (b[i]) for (int k = 7; k >= 0; k--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i][k]) ? CRC_POLY : 32'h0);
    return c;
  endfunction

  // valid stays up between packets so back-to-back needs no gap
  task automatic send_pkt();
    for (int i = 0; i < 188; i++) begin
      in_valid_i <= 1'b1;
      in_sop_i   <= (i == 0);
      in_data_i  <= pkt[i];
      do @(posedge sys_clk_i); while (in_ready_o !== 1'b1);
    end
  endtask

  task automatic wait_out(input int n);
    for (int t = 0; t < 6000 && got.size() < n; t++) @(posedge sys_clk_i);
    chk(got.size(), n);
  endtask

  task automatic wait_ev(input int n);
    for (int t = 0; t < 3000 && n_ev < n; t++) @(posedge sys_clk_i);
    chk(n_ev, n);
  endtask

  // control-message packet: pusi, pointer 0 (2 when bad), section, filler
  task automatic mk_ecm(input bit bad);
    int v, p0;
    logic [31:0] c;
    v = $urandom_range(20);
    p0 = bad ? 2 : 0;
    sec = {8'h82, 8'h30, 8'(43 + v)};
    repeat (8 + v + 31) sec.push_back(8'($urandom));
    for (int i = 0; i < 8; i++) sec[11 + i] = ko[63 - 8 * i -: 8];
    for (int i = 0; i < 8; i++) sec[19 + i] = ke[63 - 8 * i -: 8];
    c = crc_of(sec) ^ {31'h0, bad};
    for (int i = 3; i >= 0; i--) sec.push_back(c[8 * i +: 8]);
    foreach (pkt[i]) pkt[i] = 8'hFF;
    pkt[0] = 8'h47;
    pkt[1] = {3'b010, ecm_pid_i[12:8]};
    pkt[2] = ecm_pid_i[7:0];
    pkt[3] = 8'h10;
    pkt[4] = 8'(p0);
    foreach (sec[i]) pkt[5 + p0 + i] = sec[i];
  endtask

  task automatic chk_fields();
    ns = sec.size();
    chk(protocol_o, sec[8]);
    chk(group_id_o, sec[9]);
    chk(work_key_id_o, sec[10]);
    chk(prog_type_o, sec[27]);
    chk(date_time_o, {sec[28], sec[29], sec[30], sec[31], sec[32]});
    chk(rec_ctrl_o, sec[33]);
    chk(mac_o, {sec[ns-8], sec[ns-7], sec[ns-6], sec[ns-5]});
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed_v = $urandom(32'h8FEA);
    sys_key_i = {8{$urandom()}};
    ecm_pid_i = 13'h0100 | 13'($urandom_range(255));
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk(in_ready_o, 1);
    chk(out_valid_o, 0);
    chk(odd_key_o, 0);
    // good section loads keys; the sender keeps them long, one per test
    ko = {$urandom, $urandom};
    ke = ~ko;
    mk_ecm(1'b0);
    send_pkt();
    in_valid_i <= 1'b0;
    wait_ev(1);
    chk(crc_err_o, 0);
    chk(odd_key_o, ko);
    chk(even_key_o, ke);
    chk_fields();
    wait_out(188);
    foreach (pkt[i]) chk(got[i], pkt[i]);
    // corrupted crc: flagged, key pair kept
    ko = ~ke ^ 64'h1;
    mk_ecm(1'b1);
    send_pkt();
    in_valid_i <= 1'b0;
    wait_ev(2);
    chk(crc_err_o, 1);
    chk(odd_key_o, ~ke);
    chk(protocol_o, sec[8]);
    chk(even_key_o, ke);
    // drain the second packet before the stalled tests start
    wait_out(376);
    foreach (pkt[i]) chk(got[188 + i], pkt[i]);
    // table pid with scramble bits and clear pid, output stalled first
    got.delete();
    got_sop.delete();
    hold <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      foreach (pkt[i]) pkt[i] = 8'($urandom);
      pkt[0] = 8'h47;
      pkt[1] = p ? 8'h02 : 8'h00;
      pkt[2] = p ? 8'h00 : 8'h11;
      pkt[3] = p ? 8'h10 : 8'hD0;
      fork
        send_pkt();
        if (p == 0) begin
          repeat (40) @(posedge sys_clk_i);
          chk(in_ready_o, 0);
          chk(got.size(), 0);
          hold <= 1'b0;
        end
      join
      in_valid_i <= 1'b0;
      wait_out(188);
      foreach (pkt[i]) chk(got[i], pkt[i]);
      chk(got_sop[0], 1);
      got.delete();
      got_sop.delete();
    end
    // same scrambled packet odd, odd, even back to back, 4-byte tail
    foreach (pkt[i]) pkt[i] = 8'($urandom);
    pkt[0] = 8'h47;
    pkt[1] = 8'h02;
    pkt[2] = 8'h00;
    pkt[4] = 8'h03;
    for (int p = 0; p < 3; p++) begin
      pkt[3] = (p < 2) ? 8'hF0 : 8'hB0;
      send_pkt();
    end
    in_valid_i <= 1'b0;
    wait_out(564);
    for (int i = 0; i < 8; i++) if (i != 3) chk(got[i], pkt[i]);
    chk(got_sop[188], 1);
    d1 = 0;
    d2 = 0;
    d3 = 0;
    d4 = 0;
    for (int i = 8; i < 188; i++) begin
      d1 += int'(got[i] !== got[188 + i]);
      d2 += int'(got[i] !== got[376 + i]);
      d3 += int'(got[i] !== pkt[i]);
      d4 += int'(i >= 184 && got[i] !== got[376 + i]);
    end
    chk(d1, 0);
    chk(d2 > 100, 1);
    chk(d3 > 100, 1);
    chk(d4 > 0, 1);
    give_verdict();
  end

  // hang guard at 50000 cycles, well beyond the expected run of under three thousand cycles
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule
